//--- hw/sdb_ctl.sv
`timescale 1ns/1ps
`include "sdb_consts.svh"
module sdb_ctl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // memory pins
  sdb_if.ctl pins,
  // access requests
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_bank_i,
  input wire logic [12:0] req_row_i,
  input wire logic [8:0] req_col_i,
  output logic req_ready_o,
  // write data
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_data_i,
  output logic wr_ready_o,
  // read data
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  // refresh grade select, high for the 16 ms grade
  input wire logic ref_fast_i
);
  ////////////////////////////////////////////////////////////////////////
  localparam logic [3:0] TRCD_CYC = 4'(`SDB_CYC_UP(`SDB_TRCD_NS));
  localparam logic [3:0] TRC_CYC = 4'(`SDB_CYC_UP(`SDB_TRC_NS));
  localparam logic [3:0] POST_CYC = 4'(`SDB_CTL_CL + `SDB_CYC_UP(`SDB_TRP_NS));
  localparam logic [8:0] REF_STD = 9'(`SDB_REF_CYC(`SDB_REF_STD_NS));
  localparam logic [8:0] REF_HT = 9'(`SDB_REF_CYC(`SDB_REF_HT_NS));
  sdb_pkg::sdb_state_t st_q;
  sdb_pkg::sdb_cmd_t cmd_q;
  logic cke_q, cs_n_q, dqm_q, dqoe_q, wr_q;
  logic [12:0] addr_q, row_q;
  logic [1:0] bank_q;
  logic [8:0] col_q, rc_q;
  logic [15:0] dq_q;
  logic [3:0] cnt_q;
  logic [2:0] beats_q, rleft_q, rcnt_q;
  logic due_q;

  ////////////////////////////////////////////////////////////////////////
  // write data buffer
  logic pop, fifo_vld;
  logic [15:0] fifo_data;
  logic [4:0] level;
  sdb_fifo #(.WIDTH(16), .DEPTH(`SDB_FIFO_DEPTH)) u_wbuf (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(fifo_vld),
    .out_ready_i(pop),
    .out_data_o(fifo_data),
    .level_o(level)
  );
  assign pop = wr_q & fifo_vld & ((st_q == sdb_pkg::ST_RW) |
      ((st_q == sdb_pkg::ST_XFER) & (beats_q != 3'h0)));

  ////////////////////////////////////////////////////////////////////////
  // request take and refresh issue decisions
  logic take, ref_go, ref_tick;
  logic [8:0] ref_lim;
  assign take = (st_q == sdb_pkg::ST_IDLE) & req_valid_i & req_ready_o;
  assign ref_go = (st_q == sdb_pkg::ST_IDLE) & ~take & due_q;
  assign ref_lim = (ref_fast_i ? REF_HT : REF_STD) - 9'h001;
  assign ref_tick = rc_q >= ref_lim;

  // refresh interval timer; a tick wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rc_q <= 9'h000;
      due_q <= 1'b0;
    end else begin
      rc_q <= ref_tick ? 9'h000 : rc_q + 9'h001;
      if (ref_tick) begin
        due_q <= 1'b1; // [R5]
      end else if (ref_go) begin
        due_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command sequencer; every access closes its row by auto precharge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= sdb_pkg::ST_MODE;
      cmd_q <= sdb_pkg::CMD_NOP;
      cke_q <= 1'b0;
      cs_n_q <= 1'b1;
      dqm_q <= 1'b1;
      dqoe_q <= 1'b0;
      dq_q <= 16'h0000;
      addr_q <= 13'h0000;
      bank_q <= 2'h0;
      row_q <= 13'h0000;
      col_q <= 9'h000;
      wr_q <= 1'b0;
      cnt_q <= 4'h0;
      beats_q <= 3'h0;
      req_ready_o <= 1'b0;
    end else begin
      cmd_q <= sdb_pkg::CMD_NOP;
      cke_q <= 1'b1;
      cs_n_q <= 1'b0;
      dqm_q <= 1'b0;
      unique case (st_q)
        sdb_pkg::ST_MODE: begin
          cmd_q <= sdb_pkg::CMD_MRS;
          addr_q <= `SDB_CTL_MODE;
          cnt_q <= TRC_CYC;
          st_q <= sdb_pkg::ST_REC;
        end
        sdb_pkg::ST_IDLE: begin
          if (take) begin
            req_ready_o <= 1'b0;
            wr_q <= req_write_i;
            bank_q <= req_bank_i;
            row_q <= req_row_i;
            col_q <= req_col_i;
            st_q <= sdb_pkg::ST_FILL;
          end else if (ref_go) begin
            req_ready_o <= 1'b0;
            cmd_q <= sdb_pkg::CMD_REF; // [R5]
            cnt_q <= TRC_CYC;
            st_q <= sdb_pkg::ST_REC;
          end
        end
        sdb_pkg::ST_FILL: begin
          // a write waits until a whole burst is buffered
          if (~wr_q | (level >= 5'(`SDB_CTL_BL))) begin
            cmd_q <= sdb_pkg::CMD_ACT; // [R6] [R21]
            addr_q <= row_q;
            cnt_q <= TRCD_CYC - 4'h1;
            st_q <= sdb_pkg::ST_RCD;
          end
        end
        sdb_pkg::ST_RCD: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q <= sdb_pkg::ST_RW;
          end
        end
        sdb_pkg::ST_RW: begin
          cmd_q <= wr_q ? sdb_pkg::CMD_WR : sdb_pkg::CMD_RD; // [R6]
          addr_q <= {2'h0, 1'b1, 1'b0, col_q}; // [R11]
          dq_q <= fifo_data;
          dqoe_q <= wr_q;
          beats_q <= 3'(`SDB_CTL_BL - 1);
          st_q <= sdb_pkg::ST_XFER;
        end
        sdb_pkg::ST_XFER: begin
          if (beats_q != 3'h0) begin
            dq_q <= fifo_data;
            beats_q <= beats_q - 3'h1;
          end else begin
            dqoe_q <= 1'b0;
            cnt_q <= POST_CYC;
            st_q <= sdb_pkg::ST_REC;
          end
        end
        sdb_pkg::ST_REC: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            req_ready_o <= 1'b1;
            st_q <= sdb_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read capture, latency counted from the read command on the pins
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rcnt_q <= 3'h0;
      rleft_q <= 3'h0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 16'h0000;
    end else begin
      rd_valid_o <= 1'b0;
      if ((st_q == sdb_pkg::ST_RW) & ~wr_q) begin
        rcnt_q <= 3'(`SDB_CTL_CL + 1);
        rleft_q <= 3'(`SDB_CTL_BL);
      end else begin
        if (rcnt_q != 3'h0) begin
          rcnt_q <= rcnt_q - 3'h1;
        end
        if ((rleft_q != 3'h0) & (rcnt_q <= 3'h1)) begin
          rleft_q <= rleft_q - 3'h1;
          rd_valid_o <= 1'b1; // [R1]
          rd_data_o <= pins.dq;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive
  assign pins.cke = cke_q;
  assign pins.cs_n = cs_n_q;
  assign {pins.ras_n, pins.cas_n, pins.we_n} = cmd_q;
  assign pins.addr = addr_q;
  assign pins.bank_select_bit0 = bank_q[0];
  assign pins.bank_select_bit1 = bank_q[1];
  assign pins.low_byte_mask = dqm_q;
  assign pins.high_byte_mask = dqm_q;
  assign pins.ctl_dq = dq_q;
  assign pins.ctl_dq_oe = dqoe_q;
endmodule

//--- hw/sdb_consts.svh
`ifndef SDB_CONSTS_SVH
`define SDB_CONSTS_SVH
// array geometry, x16 variant
`define SDB_ROWS 8192
`define SDB_COLS 512
`define SDB_AP_BIT 10
`define SDB_MEM_WORDS 64
// mode word fields
`define SDB_MR_BL_LSB 0
`define SDB_MR_BT_BIT 3
`define SDB_MR_CL_LSB 4
`define SDB_MR_WB_BIT 9
`define SDB_BL_FULL 3'h7
`define SDB_CL_THREE 3'h3
`define SDB_MR_RESET 13'h0022
// controller operating point: burst 4, sequential, latency 3
`define SDB_CTL_MODE 13'h0032
`define SDB_CTL_BL 4
`define SDB_CTL_CL 3
// timing
`define SDB_CLK_NS 20
`define SDB_REF_STD_NS 64000000
`define SDB_REF_HT_NS 16000000
`define SDB_TRCD_NS 20
`define SDB_TRP_NS 20
`define SDB_TRC_NS 70
`define SDB_CYC_UP(t) (((t) + `SDB_CLK_NS - 1) / `SDB_CLK_NS)
`define SDB_REF_CYC(p) ((p) / `SDB_ROWS / `SDB_CLK_NS)
`define SDB_FIFO_DEPTH 16
`endif

//--- hw/sdb_pkg.sv
package sdb_pkg;
  // command code is {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sdb_cmd_t;
  // controller sequencing
  typedef enum logic [2:0] {
    ST_MODE, ST_IDLE, ST_FILL, ST_RCD, ST_RW, ST_XFER, ST_REC
  } sdb_state_t;
endpackage

//--- hw/sdb_if.sv
`timescale 1ns/1ps
interface sdb_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [12:0] addr;
  logic bank_select_bit0;
  logic bank_select_bit1;
  logic low_byte_mask;
  logic high_byte_mask;
  logic [15:0] ctl_dq;
  logic ctl_dq_oe;
  logic [15:0] dev_dq;
  logic [1:0] dev_dq_oe;
  logic [15:0] dq;
  // resolved data bus per byte; an undriven byte reads as zero
  assign dq[7:0] = dev_dq_oe[0] ? dev_dq[7:0] : (ctl_dq_oe ? ctl_dq[7:0] : 8'h00);
  assign dq[15:8] = dev_dq_oe[1] ? dev_dq[15:8] : (ctl_dq_oe ? ctl_dq[15:8] : 8'h00);
  modport dev (
    input cke, cs_n, ras_n, cas_n, we_n, addr, bank_select_bit0, bank_select_bit1,
    input low_byte_mask, high_byte_mask, dq,
    output dev_dq, dev_dq_oe
  );
  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, addr, bank_select_bit0, bank_select_bit1,
    output low_byte_mask, high_byte_mask, ctl_dq, ctl_dq_oe,
    input dq
  );
endinterface

//--- hw/sdb_fifo.sv
`timescale 1ns/1ps
module sdb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;
  // handshakes and next fill level
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  assign out_data_o = mem_q[rd_q];
  assign level_o = cnt_q;
  // pointers and registered flags
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wr_q <= wr_q + PW'(push);
      rd_q <= rd_q + PW'(pop);
      cnt_q <= cnt_d;
      in_ready_o <= cnt_d != (PW+1)'(DEPTH);
      out_valid_o <= cnt_d != '0;
    end
  end
  // storage
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

//--- hw/sdb_dev.sv
`timescale 1ns/1ps
`include "sdb_consts.svh"
// Notes on behaviour
// [R1] everything sampled on rising clock edge only
// [R2] burst length 1, 2, 4, 8 or page
// [R3] burst order sequential or interleaved
// [R4] read latency two or three clocks
// [R5] controller refreshes 8K rows per 64/16 ms
// [R6] activate bank and row, then read/write
// [R7] 8192 rows, 512 x16 or 1024 x8 columns
// [R8] four banks, each with own open row
// [R9] command gives start column, rest generated
// [R10] new column accepted every clock
// [R11] auto-precharge bit closes row after burst
// [R12] precharge one bank while another bursts
// [R13] burst stop or precharge truncates burst
// [R14] optional single-location writes, burst reads
// [R15] separate low and high byte masks
// [R16] chip select high blocks new commands
// [R17] edge ignored while clock gate low
// [R18] read mask tristates data two clocks later
// [R19] precharge with bit high closes all banks
// [R20] generated columns wrap within aligned block
// [R21] controller accesses only activated banks
module sdb_dev (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // memory pins
  sdb_if.dev pins,
  // status
  output logic [3:0] bank_open_o,
  output logic burst_busy_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [12:0] mode_q;
  logic [3:0] open_q;
  logic [12:0] row_q [4];
  logic [15:0] mem_q [`SDB_MEM_WORDS];
  logic bact_q, brd_q, bap_q, bfull_q, bseq_q;
  logic [1:0] bbank_q;
  logic [8:0] bstart_q, bk_q;
  logic [9:0] blen_q;
  logic [15:0] s1_q, s2_q, dq_q;
  logic s1v_q, s2v_q;
  logic [1:0] dm1_q, oe_q;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  sdb_pkg::sdb_cmd_t cmd;
  logic edge_ok, sel, ap;
  logic [1:0] cbank;
  logic is_act, is_rd, is_wr, is_pre, is_bst, is_mrs, new_rw;
  assign edge_ok = pins.cke; // [R17]
  assign sel = ~pins.cs_n; // [R16]
  assign cmd = sdb_pkg::sdb_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
  assign cbank = {pins.bank_select_bit1, pins.bank_select_bit0};
  assign ap = pins.addr[`SDB_AP_BIT];
  assign is_act = sel & (cmd == sdb_pkg::CMD_ACT);
  assign is_rd = sel & (cmd == sdb_pkg::CMD_RD);
  assign is_wr = sel & (cmd == sdb_pkg::CMD_WR);
  assign is_pre = sel & (cmd == sdb_pkg::CMD_PRE);
  assign is_bst = sel & (cmd == sdb_pkg::CMD_BST);
  assign is_mrs = sel & (cmd == sdb_pkg::CMD_MRS);
  assign new_rw = is_rd | is_wr;

  ////////////////////////////////////////////////////////////////////////
  // mode word decode
  logic [2:0] bl_code;
  logic full_pg, wr_single, cl3, cmd_last, cmd_full;
  logic [9:0] len, cmd_len;
  assign bl_code = mode_q[`SDB_MR_BL_LSB +: 3];
  assign full_pg = bl_code == `SDB_BL_FULL;
  assign len = full_pg ? 10'h200 : (10'h001 << bl_code[1:0]); // [R2]
  assign wr_single = mode_q[`SDB_MR_WB_BIT];
  assign cmd_len = (is_wr & wr_single) ? 10'h001 : len; // [R14]
  assign cmd_full = full_pg & ~(is_wr & wr_single);
  assign cmd_last = cmd_len == 10'h001;
  assign cl3 = mode_q[`SDB_MR_CL_LSB +: 3] == `SDB_CL_THREE; // [R4]

  ////////////////////////////////////////////////////////////////////////
  // internal column generation
  logic [8:0] bmask, gen_seq, gen_int, gen_col;
  assign bmask = blen_q[8:0] - 9'h001;
  assign gen_seq = (bstart_q & ~bmask) | ((bstart_q + bk_q) & bmask); // [R20]
  assign gen_int = (bstart_q & ~bmask) | ((bstart_q ^ bk_q) & bmask);
  assign gen_col = (bseq_q | bfull_q) ? gen_seq : gen_int; // [R3]

  ////////////////////////////////////////////////////////////////////////
  // access of this edge: a new command wins over the running burst
  logic stop, last, acc_on, acc_rd, close_en;
  logic [1:0] acc_bank, close_bank;
  logic [8:0] acc_col;
  logic [5:0] idx;
  assign stop = is_bst | (is_pre & (ap | (cbank == bbank_q))); // [R13]
  assign last = ~bfull_q & (({1'b0, bk_q} + 10'h001) == blen_q);
  assign acc_on = new_rw | (bact_q & ~stop);
  assign acc_rd = new_rw ? is_rd : brd_q;
  assign acc_bank = new_rw ? cbank : bbank_q;
  assign acc_col = new_rw ? pins.addr[8:0] : gen_col; // [R9] [R10]
  assign idx = {acc_bank, row_q[acc_bank][0], acc_col[2:0]};
  // self-timed close when the burst runs out with the precharge bit set
  assign close_en = (new_rw & ap & cmd_last) | (bact_q & ~new_rw & ~stop & last & bap_q);
  assign close_bank = new_rw ? cbank : bbank_q; // [R11]

  ////////////////////////////////////////////////////////////////////////
  // burst tracker
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bact_q <= 1'b0;
      brd_q <= 1'b0;
      bap_q <= 1'b0;
      bfull_q <= 1'b0;
      bseq_q <= 1'b1;
      bbank_q <= 2'h0;
      bstart_q <= 9'h000;
      bk_q <= 9'h000;
      blen_q <= 10'h001;
    end else if (edge_ok) begin // [R1] [R17]
      if (new_rw) begin
        bact_q <= ~cmd_last;
        brd_q <= is_rd;
        bap_q <= ap & ~cmd_full;
        bfull_q <= cmd_full;
        bseq_q <= ~mode_q[`SDB_MR_BT_BIT];
        bbank_q <= cbank;
        bstart_q <= pins.addr[8:0];
        bk_q <= 9'h001;
        blen_q <= cmd_len;
      end else if (bact_q) begin
        bact_q <= ~(stop | last); // [R13]
        bk_q <= bk_q + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bank and mode state
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mode_q <= `SDB_MR_RESET;
      open_q <= 4'h0;
    end else if (edge_ok) begin
      if (is_mrs & (open_q == 4'h0)) begin
        mode_q <= pins.addr;
      end
      if (close_en) begin
        open_q[close_bank] <= 1'b0; // [R11]
      end
      if (is_act) begin
        open_q[cbank] <= 1'b1; // [R6] [R8]
      end
      if (is_pre & ap) begin
        open_q <= 4'h0; // [R19]
      end else if (is_pre) begin
        open_q[cbank] <= 1'b0; // [R12] [R19]
      end
    end
  end

  // open row per bank
  always_ff @(posedge ref_clk_i) begin
    if (edge_ok & is_act) begin
      row_q[cbank] <= pins.addr; // [R6] [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array write with per-byte masks; an idle bank is not written
  always_ff @(posedge ref_clk_i) begin
    if (edge_ok & acc_on & ~acc_rd & open_q[acc_bank]) begin
      if (~pins.low_byte_mask) begin
        mem_q[idx][7:0] <= pins.dq[7:0]; // [R15]
      end
      if (~pins.high_byte_mask) begin
        mem_q[idx][15:8] <= pins.dq[15:8]; // [R15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read pipeline: stage taps pick the latency
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s1v_q <= 1'b0;
      s2v_q <= 1'b0;
      dm1_q <= 2'h3;
      dq_q <= 16'h0000;
      oe_q <= 2'h0;
    end else if (edge_ok) begin
      s1_q <= mem_q[idx];
      s1v_q <= acc_on & acc_rd & open_q[acc_bank];
      s2_q <= s1_q;
      s2v_q <= s1v_q;
      dm1_q <= {pins.high_byte_mask, pins.low_byte_mask};
      dq_q <= cl3 ? s2_q : s1_q; // [R4]
      oe_q <= {2{cl3 ? s2v_q : s1v_q}} & ~dm1_q; // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign pins.dev_dq = dq_q;
  assign pins.dev_dq_oe = oe_q;
  assign bank_open_o = open_q;
  assign burst_busy_o = bact_q;
endmodule

//--- verification/sdb_checker.sv
`timescale 1ns/1ps
module sdb_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // memory pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic ctl_dq_oe,
  input wire logic [1:0] dev_dq_oe
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // command decode, only on enabled and selected edges
  wire logic [2:0] cmd_w = {ras_n, cas_n, we_n};
  wire logic live_w = cke & ~cs_n;
  wire logic rd_w = live_w & (cmd_w == sdb_pkg::CMD_RD);
  wire logic wr_w = live_w & (cmd_w == sdb_pkg::CMD_WR);
  wire logic act_w = live_w & (cmd_w == sdb_pkg::CMD_ACT);
  wire logic ref_w = live_w & (cmd_w == sdb_pkg::CMD_REF);
  logic [9:0] gap_q;
  // cycles since the last refresh command
  always_ff @(posedge ref_clk_i) begin
    gap_q <= (srst_i | ref_w) ? 10'h000 : gap_q + 10'h001;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_RD_LAT: assert property (rd_w |-> ##3 (dev_dq_oe == 2'h3)[*4] ##1 dev_dq_oe == 2'h0)
    else $error("read burst not four beats three cycles after command");
  AST_WR_DATA: assert property (wr_w |-> ctl_dq_oe[*4] ##1 !ctl_dq_oe)
    else $error("write data not driven for four beats from command");
  AST_ACT_FIRST: assert property ((rd_w | wr_w) |-> $past(act_w, 2))
    else $error("column command without activate two cycles before");
  AST_AP_SET: assert property ((rd_w | wr_w) |-> addr[10])
    else $error("column command without auto precharge");
  AST_AP_QUIET: assert property ((rd_w | wr_w) |-> ##1 (!act_w)[*8])
    else $error("activate too soon after an auto precharge access");
  AST_REF_GAP: assert property (gap_q <= 10'h19A)
    else $error("refresh interval too long");
  AST_MRS_FIRST: assert property ($fell(srst_i) |->
    ##[0:2] (live_w && cmd_w == sdb_pkg::CMD_MRS && addr == 13'h0032))
    else $error("mode load missing after reset");
  AST_NO_CLASH: assert property (!(ctl_dq_oe && dev_dq_oe != 2'h0))
    else $error("both ends drive the data bus");
  // main scenarios
  cover property (rd_w);
  cover property (wr_w);
  cover property (ref_w);
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
`include "sdb_consts.svh"
module tb_top;
  logic ref_clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic req_valid_i = 1'h0;
  logic req_write_i = 1'h0;
  logic [1:0] req_bank_i = 2'h0;
  logic [12:0] req_row_i = 13'h0000;
  logic [8:0] req_col_i = 9'h000;
  logic wr_valid_i = 1'h0;
  logic [15:0] wr_data_i = 16'h0000;
  logic ref_fast_i = 1'h0;
  logic req_ready_o, wr_ready_o, rd_valid_o, busy_a, busy_b;
  logic [15:0] rd_data_o;
  logic [3:0] open_a, open_b;
  logic [15:0] mem_a [80];
  logic [15:0] mem_b [8];
  int num_errors = 0;
  int samples_checked = 0;
  int refs = 0;
  // {cke, cs_n, command, bank, bit10, expected open banks}
  localparam logic [11:0] BANK_SEQ [6] = '{{5'h03, 2'h1, 1'h0, 4'h0}, {5'h1B, 2'h1, 1'h0, 4'h0},
    {5'h13, 2'h1, 1'h0, 4'h2}, {5'h13, 2'h3, 1'h0, 4'hA}, {5'h12, 2'h1, 1'h0, 4'h8},
    {5'h12, 2'h0, 1'h1, 4'h0}};
  sdb_if bus_a ();
  sdb_if bus_b ();
  ////////////////////////////////////////////////////////////////////////////////
  // controller and device facing each other, second device driven by the bench
  sdb_ctl sdb_ctl_i (.ref_clk_i, .srst_i, .pins(bus_a), .req_valid_i, .req_write_i, .req_bank_i,
    .req_row_i, .req_col_i, .req_ready_o, .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o,
    .rd_data_o, .ref_fast_i);
  sdb_dev sdb_dev_i (.ref_clk_i, .srst_i, .pins(bus_a), .bank_open_o(open_a), .burst_busy_o(busy_a));
  sdb_dev sdb_dev_b_i (.ref_clk_i, .srst_i, .pins(bus_b), .bank_open_o(open_b),
    .burst_busy_o(busy_b));
  sdb_checker sdb_checker_i (.ref_clk_i, .srst_i, .cke(bus_a.cke), .cs_n(bus_a.cs_n),
    .ras_n(bus_a.ras_n), .cas_n(bus_a.cas_n), .we_n(bus_a.we_n), .addr(bus_a.addr),
    .ctl_dq_oe(bus_a.ctl_dq_oe), .dev_dq_oe(bus_a.dev_dq_oe));
  // clock and refresh counter
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (bus_a.cke && !bus_a.cs_n && {bus_a.ras_n, bus_a.cas_n, bus_a.we_n} == sdb_pkg::CMD_REF) begin
      refs++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // column of beat k for a mode word and start column
  function automatic logic [8:0] col_at(input logic [12:0] mode, input logic [8:0] s, input int k);
    logic [8:0] m;
    m = (mode[2:0] == 3'h7) ? 9'h1FF : 9'((1 << mode[1:0]) - 1);
    return (s & ~m) | ((mode[3] ? (s ^ 9'(k)) : (s + 9'(k))) & m);
  endfunction
  // one edge on the second device: {cke, cs_n, cmd}, bank, address, data, {oe, masks}
  task automatic drv(input logic [4:0] c, input logic [1:0] b, input logic [12:0] a,
                     input logic [15:0] d, input logic [2:0] m);
    {bus_b.cke, bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} <= c;
    {bus_b.bank_select_bit1, bus_b.bank_select_bit0} <= b;
    bus_b.addr <= a;
    bus_b.ctl_dq <= d;
    {bus_b.ctl_dq_oe, bus_b.high_byte_mask, bus_b.low_byte_mask} <= m;
    @(posedge ref_clk_i);
  endtask
  // program a mode, write columns 0 to 7, read a burst from a random start
  task automatic dev_pass(input logic [12:0] mode, input logic ap, input int stop);
    int cl, len, ix;
    logic [15:0] d, msk;
    logic [8:0] s, x;
    cl = (mode[6:4] == 3'h3) ? 3 : 2;
    len = (mode[2:0] == 3'h7) ? stop : (1 << mode[1:0]);
    s = 9'($urandom);
    drv(5'h12, 2'h0, 13'h0400, 16'h0000, 3'h0);
    drv(5'h10, 2'h0, mode, 16'h0000, 3'h0);
    drv(5'h13, 2'h2, 13'($urandom), 16'h0000, 3'h0);
    for (int k = 0; k < 9; k++) begin
      d = 16'($urandom);
      ix = (k == 8) ? 5 : k;
      mem_b[ix] = (k == 8) ? {mem_b[5][15:8], d[7:0]} : d;
      drv(5'h14, 2'h2, 13'(ix), d, {1'h1, k == 8, 1'h0});
    end
    repeat (2) drv(mode[9] ? 5'h17 : 5'h16, 2'h2, 13'h0000, 16'hFFFF, {1'h1, ~mode[9], ~mode[9]});
    drv(5'h15, 2'h2, {2'h0, ap, 1'h0, s}, 16'h0000, 3'h0);
    for (int t = 1; t <= cl + len; t++) begin
      drv((t == stop) ? 5'h16 : 5'h17, 2'h2, 13'h0000, 16'h0000, {2'h0, t == cl - 1});
      chk(16'(busy_b), 16'(t < len || t == stop));
      if (t >= cl) begin
        ix = t - cl;
        x = col_at(mode, s, ix);
        msk = (ix == 1) ? 16'hFF00 : 16'hFFFF;
        chk(16'(bus_b.dev_dq_oe), (ix >= len) ? 16'h0000 : 16'(msk[1:0] | 2'h2));
        if (ix < len) begin
          chk(bus_b.dq & msk, mem_b[x[2:0]] & msk);
        end
      end
    end
    chk(16'(open_b[2]), 16'(!ap));
  endtask
  task automatic req(input logic w, input logic [1:0] b, input logic [12:0] r, input logic [8:0] c);
    int n;
    n = 0;
    req_valid_i <= 1'h1;
    req_write_i <= w;
    req_bank_i <= b;
    req_row_i <= r;
    req_col_i <= c;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (req_ready_o !== 1'h1 && n < 500);
    chk(16'(req_ready_o), 16'h0001);
    req_valid_i <= 1'h0;
    // one idle edge keeps back-to-back requests from re-driving valid at once
    @(posedge ref_clk_i);
  endtask
  // fill the write buffer until refused, store four bursts, read them back
  task automatic ctl_test();
    logic [12:0] r [4];
    logic [8:0] c [4];
    logic [8:0] s, x;
    int n;
    for (int i = 0; i < 16; i++) begin
      wr_valid_i <= 1'h1;
      wr_data_i <= 16'($urandom);
      mem_a[i] = wr_data_i;
      n = 0;
      do begin
        @(posedge ref_clk_i);
        n++;
      end while (wr_ready_o !== 1'h1 && n < 50);
      chk(16'(wr_ready_o), 16'h0001);
      mem_a[i] = wr_data_i;
    end
    wr_valid_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    chk(16'(wr_ready_o), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r[i] = 13'($urandom);
      c[i] = 9'($urandom);
      req(1'h1, 2'(i), r[i], c[i]);
      for (int k = 0; k < 4; k++) begin
        x = col_at(`SDB_CTL_MODE, c[i], k);
        mem_a[{2'(i), r[i][0], x[2:0]} + 16] = mem_a[4 * i + k];
      end
    end
    for (int i = 0; i < 4; i++) begin
      s = (9'($urandom) & 9'h1FB) | (c[i] & 9'h004);
      req(1'h0, 2'(i), r[i], s);
      for (int k = 0; k < 4; k++) begin
        n = 0;
        do begin
          @(posedge ref_clk_i);
          n++;
        end while (rd_valid_o !== 1'h1 && n < 40);
        chk(16'(rd_valid_o), 16'h0001);
        x = col_at(`SDB_CTL_MODE, s, k);
        chk(rd_data_o, mem_a[{2'(i), r[i][0], x[2:0]} + 16]);
      end
    end
    chk(16'(wr_ready_o), 16'h0001);
    chk(16'({busy_a, open_a}), 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h85D5));
    drv(5'h0F, 2'h0, 13'h0000, 16'h0000, 3'h0);
    repeat (15) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    drv(5'h17, 2'h0, 13'h0000, 16'h0000, 3'h0);
    foreach (BANK_SEQ[i]) begin
      drv(BANK_SEQ[i][11:7], BANK_SEQ[i][6:5], {2'h0, BANK_SEQ[i][4], 10'h000}, 16'h0000, 3'h0);
      drv(5'h17, 2'h0, 13'h0000, 16'h0000, 3'h0);
      chk(16'(open_b), 16'(BANK_SEQ[i][3:0]));
    end
    $display("bank test done");
    dev_pass(13'h0020, 1'h0, 0);
    dev_pass(13'h0039, 1'h0, 0);
    dev_pass(13'h0232, 1'h0, 0);
    dev_pass(13'h002B, 1'h1, 0);
    dev_pass(13'h0027, 1'h0, 5);
    $display("burst mode test done");
    ctl_test();
    $display("controller test done");
    ref_fast_i <= 1'h1;
    refs = 0;
    repeat (500) @(posedge ref_clk_i);
    chk(16'(refs >= 4), 16'h0001);
    $display("refresh test done");
    end_sim();
  end
  // watchdog
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule
